// [rtl/osrc_defines.svh]
`ifndef OSRC_DEFINES_SVH
`define OSRC_DEFINES_SVH

// Register byte addresses (session control index 0x12 is not a multiple of four)
`define OSRC_IDX_SESSION_CTRL 6'h12
`define OSRC_ADDR_SESSION_CTRL 8'h48
`define OSRC_ADDR_MODE 8'h4C
`define OSRC_ADDR_IRQ_STATUS 8'h50
`define OSRC_ADDR_IRQ_MASK 8'h54

// Session control field positions
`define OSRC_BIT_DUAL_ROLE 0
`define OSRC_BIT_VBUS_PULSE 1
`define OSRC_BIT_DISCHARGE 2
`define OSRC_BIT_INIT_VIOL 3
`define OSRC_BIT_SESS_VALID 4
`define OSRC_BIT_DATA_PULSE 5

// Mode register field position
`define OSRC_BIT_PULLUP 0

// Interrupt status layout
`define OSRC_IRQ_SESS_VALID 0
`define OSRC_IRQ_INIT_VIOL 1
`define OSRC_IRQ_VBUS_SENSE 2
`define OSRC_IRQ_WIDTH 3

// Reset values
`define OSRC_CTRL_RESET 4'h0
`define OSRC_MASK_RESET 3'h0

// VBUS pulse window, time in ms and its cycle count at 40 MHz
`define OSRC_CLK_HZ 40000000
`define OSRC_VBUS_PULSE_MIN_MS 16
`define OSRC_VBUS_PULSE_MIN_CYC ((`OSRC_VBUS_PULSE_MIN_MS * `OSRC_CLK_HZ + 999) / 1000)
`define OSRC_VBUS_PULSE_MAX_MS 26
`define OSRC_VBUS_PULSE_MAX_CYC ((`OSRC_VBUS_PULSE_MAX_MS * `OSRC_CLK_HZ) / 1000)

`endif

// [rtl/osrc_pkg.sv]
package osrc_pkg;

   // Avalon-MM request from the master
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } osrc_avmm_req_type;

   // Avalon-MM answer to the master
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } osrc_avmm_rsp_type;

   // Analog comparator inputs from the transceiver
   typedef struct packed {
      logic vbus_above_session_valid;
      logic vbus_below_0v8;
      logic lines_at_se0;
      logic vbus_sense_event;
   } osrc_analog_type;

   // Drive controls toward the transceiver
   typedef struct packed {
      logic data_line_pulse;
      logic vbus_pulse;
      logic vbus_discharge;
      logic bus_pullup_connect;
      logic vbus_sense_enable;
   } osrc_drive_type;

   typedef enum logic [1:0] {
      OSRC_BUS_IDLE = 2'b00,
      OSRC_BUS_ACK = 2'b01
   } osrc_bus_state_type;

   // Whole block state
   typedef struct packed {
      osrc_bus_state_type bus_state;
      logic [31:0] readdata;
      logic dual_role_enable;
      logic vbus_pulse;
      logic vbus_discharge;
      logic data_line_pulse;
      logic b_session_valid_latch;
      logic initial_condition_violation;
      logic bus_pullup_connect;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic [25:0] pulse_count;
      logic pulse_too_short;
      logic pulse_too_long;
   } osrc_state_type;

endpackage

// [rtl/osrc_session_request.sv]
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "osrc_defines.svh"
module osrc_session_request (
   input wire logic clk_sys,
   input wire logic reset,
   input wire osrc_pkg::osrc_avmm_req_type avmm_req,
   output osrc_pkg::osrc_avmm_rsp_type avmm_rsp,
   input wire osrc_pkg::osrc_analog_type analog_in,
   output osrc_pkg::osrc_drive_type drive_out,
   output logic irq
);
   import osrc_pkg::*;

   localparam logic [25:0] PULSE_MIN_CYC = 26'(`OSRC_VBUS_PULSE_MIN_CYC);
   localparam logic [25:0] PULSE_MAX_CYC = 26'(`OSRC_VBUS_PULSE_MAX_CYC);

   osrc_state_type state_reg;
   osrc_state_type state_next;

   ////////////////////////////////////////////////////////////////////////
   // Register read image

   // Session control byte; status bits read zero while dual-role is off
   function automatic logic [7:0] ctrl_image(input osrc_state_type s);
      logic [7:0] v;
      v = 8'h00;
      v[`OSRC_BIT_DUAL_ROLE] = s.dual_role_enable;
      v[`OSRC_BIT_VBUS_PULSE] = s.vbus_pulse;
      v[`OSRC_BIT_DISCHARGE] = s.vbus_discharge;
      v[`OSRC_BIT_DATA_PULSE] = s.data_line_pulse;
      v[`OSRC_BIT_INIT_VIOL] = s.dual_role_enable & s.initial_condition_violation;
      v[`OSRC_BIT_SESS_VALID] = s.dual_role_enable & s.b_session_valid_latch;
      return v;
   endfunction

   // Byte address decode shared by read and write paths
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
      return a == target;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Bus slave, session latches, pulse timer and interrupt status
   always_comb begin
      logic wr;
      logic rd;
      logic [31:0] wd;
      logic [2:0] events;
      wr = 1'b0;
      rd = 1'b0;
      wd = avmm_req.writedata;
      events = 3'h0;
      state_next = state_reg;

      // One wait cycle, then acknowledge; commit only on the ack cycle
      unique case (state_reg.bus_state)
         OSRC_BUS_IDLE: begin
            if (avmm_req.read || avmm_req.write) begin
               state_next.bus_state = OSRC_BUS_ACK;
            end
         end
         OSRC_BUS_ACK: begin
            state_next.bus_state = OSRC_BUS_IDLE;
            wr = avmm_req.write;
            rd = avmm_req.read;
         end
         default: begin
            state_next.bus_state = OSRC_BUS_IDLE;
         end
      endcase

      // Read data built in the wait cycle so it stands at the ack edge
      if (state_reg.bus_state == OSRC_BUS_IDLE && avmm_req.read) begin
         state_next.readdata = 32'h0000_0000;
         if (addr_hit(avmm_req.address, `OSRC_ADDR_SESSION_CTRL)) begin
            state_next.readdata[7:0] = ctrl_image(state_reg);
         end else if (addr_hit(avmm_req.address, `OSRC_ADDR_MODE)) begin
            state_next.readdata[`OSRC_BIT_PULLUP] = state_reg.bus_pullup_connect;
         end else if (addr_hit(avmm_req.address, `OSRC_ADDR_IRQ_STATUS)) begin
            state_next.readdata[2:0] = state_reg.irq_status;
         end else if (addr_hit(avmm_req.address, `OSRC_ADDR_IRQ_MASK)) begin
            state_next.readdata[2:0] = state_reg.irq_mask;
         end
      end

      // Control bit writes; reserved bits 7:6 simply dropped
      if (wr && addr_hit(avmm_req.address, `OSRC_ADDR_SESSION_CTRL)) begin
         state_next.dual_role_enable = wd[`OSRC_BIT_DUAL_ROLE];
         state_next.vbus_pulse = wd[`OSRC_BIT_VBUS_PULSE];
         state_next.vbus_discharge = wd[`OSRC_BIT_DISCHARGE];
         state_next.data_line_pulse = wd[`OSRC_BIT_DATA_PULSE];
         if (wd[`OSRC_BIT_SESS_VALID]) begin
            state_next.b_session_valid_latch = 1'b0;
         end
         if (wd[`OSRC_BIT_INIT_VIOL]) begin
            state_next.initial_condition_violation = 1'b0;
         end
      end
      if (wr && addr_hit(avmm_req.address, `OSRC_ADDR_MODE)) begin
         state_next.bus_pullup_connect = wd[`OSRC_BIT_PULLUP];
      end
      if (wr && addr_hit(avmm_req.address, `OSRC_ADDR_IRQ_MASK)) begin
         state_next.irq_mask = wd[2:0];
      end

      // Hardware set wins over a clear in the same cycle
      if (analog_in.vbus_above_session_valid) begin
         state_next.b_session_valid_latch = 1'b1;
      end
      if (!analog_in.vbus_below_0v8 || !analog_in.lines_at_se0) begin
         state_next.initial_condition_violation = 1'b1;
      end

      // VBUS pulse length monitor, diagnostic only
      if (state_reg.dual_role_enable && state_reg.vbus_pulse) begin
         if (state_reg.pulse_count != PULSE_MAX_CYC + 26'd1) begin
            state_next.pulse_count = state_reg.pulse_count + 26'd1;
         end
         if (state_reg.pulse_count == PULSE_MAX_CYC) begin
            state_next.pulse_too_long = 1'b1;
         end
      end else begin
         state_next.pulse_count = 26'd0;
      end
      if (state_reg.vbus_pulse && !state_next.vbus_pulse) begin
         state_next.pulse_too_short = state_reg.pulse_count < PULSE_MIN_CYC;
         state_next.pulse_too_long = 1'b0;
      end

      // Events: session-valid and violation rise, plus VBUS sensing
      events[`OSRC_IRQ_SESS_VALID] = state_next.b_session_valid_latch
         & ~state_reg.b_session_valid_latch & state_reg.dual_role_enable;
      events[`OSRC_IRQ_INIT_VIOL] = state_next.initial_condition_violation
         & ~state_reg.initial_condition_violation & state_reg.dual_role_enable;
      events[`OSRC_IRQ_VBUS_SENSE] = analog_in.vbus_sense_event;

      // Read of status clears it; a new event in that cycle survives
      if (rd && addr_hit(avmm_req.address, `OSRC_ADDR_IRQ_STATUS)) begin
         state_next.irq_status = 3'h0;
      end
      state_next.irq_status = state_next.irq_status | events;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   // Asynchronous reset to constants only
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.bus_state <= OSRC_BUS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Waitrequest drops only in the acknowledge cycle
   assign avmm_rsp.waitrequest = !(state_reg.bus_state == OSRC_BUS_ACK);
   assign avmm_rsp.readdata = state_reg.readdata;

   // Pulse and discharge drives masked unless dual-role is on; pull-up not masked
   assign drive_out.data_line_pulse = state_reg.dual_role_enable & state_reg.data_line_pulse;
   assign drive_out.vbus_pulse = state_reg.dual_role_enable & state_reg.vbus_pulse;
   assign drive_out.vbus_discharge = state_reg.dual_role_enable & state_reg.vbus_discharge;
   assign drive_out.vbus_sense_enable = !state_reg.dual_role_enable;
   assign drive_out.bus_pullup_connect = state_reg.bus_pullup_connect;

   // Level interrupt from any unmasked sticky bit
   assign irq = |(state_reg.irq_status & state_reg.irq_mask);

endmodule

// [verification/osrc_session_request_assertions.sv]
`timescale 1ns/1ps
`include "osrc_defines.svh"
module osrc_sr_assertions (
   input wire logic clk_sys,
   input wire logic reset,
   input wire osrc_pkg::osrc_avmm_req_type avmm_req,
   input wire osrc_pkg::osrc_avmm_rsp_type avmm_rsp,
   input wire osrc_pkg::osrc_analog_type analog_in,
   input wire osrc_pkg::osrc_drive_type drive_out,
   input wire logic irq
);
   import osrc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   // Write accepted at this edge, then the written data bit
   sequence s_wr(a);
      avmm_req.write && !avmm_rsp.waitrequest && avmm_req.address == a;
   endsequence
   sequence s_ctrl(b);
      s_wr(`OSRC_ADDR_SESSION_CTRL) ##0 avmm_req.writedata[0] == b;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // Bus answers after exactly one wait cycle
   AST_ACK_BOUND: assert property ((avmm_req.read || avmm_req.write) && avmm_rsp.waitrequest
      |=> !avmm_rsp.waitrequest) else $error("request not answered in one cycle");
   AST_ACK_ONE: assert property (!avmm_rsp.waitrequest |=> avmm_rsp.waitrequest)
      else $error("acknowledge longer than one cycle");
   AST_RSVD: assert property (avmm_rsp.readdata[31:6] == 26'h0)
      else $error("reserved read bits not zero");
   // Any pulse or discharge drive implies sensing is off
   AST_SENSE_OFF: assert property ((drive_out.data_line_pulse || drive_out.vbus_pulse ||
      drive_out.vbus_discharge) |-> !drive_out.vbus_sense_enable) else $error("sense on");
   AST_CTRL_ON: assert property (s_ctrl(1'b1) |=> !drive_out.vbus_sense_enable &&
      drive_out.data_line_pulse == $past(avmm_req.writedata[5]) &&
      drive_out.vbus_pulse == $past(avmm_req.writedata[1]) &&
      drive_out.vbus_discharge == $past(avmm_req.writedata[2])) else $error("ctrl drive wrong");
   AST_CTRL_OFF: assert property (s_ctrl(1'b0) |=> drive_out.vbus_sense_enable &&
      !(drive_out.data_line_pulse || drive_out.vbus_pulse || drive_out.vbus_discharge))
      else $error("controls not masked");
   AST_PULLUP: assert property (s_wr(`OSRC_ADDR_MODE)
      |=> drive_out.bus_pullup_connect == $past(avmm_req.writedata[0])) else $error("pullup");
   // Drives move only on an accepted write
   AST_HOLD: assert property (!(avmm_req.write && !avmm_rsp.waitrequest) |=>
      $stable(drive_out)) else $error("drive changed without write");
endmodule

// [verification/osrc_host_model.sv]
`timescale 1ns/1ps
module osrc_host_model (
   input wire osrc_pkg::osrc_drive_type drive_out,
   input wire logic sess_on,
   input wire logic lines_busy,
   input wire logic sense_evt,
   output osrc_pkg::osrc_analog_type analog_in
);
   import osrc_pkg::*;
   // Host powers VBUS once it answers; device pulsing lifts VBUS too
   assign analog_in.vbus_above_session_valid = sess_on;
   assign analog_in.vbus_below_0v8 = !sess_on && !drive_out.vbus_pulse;
   // Pulsing or an attached pull-up leaves SE0
   assign analog_in.lines_at_se0 = !lines_busy && !drive_out.data_line_pulse &&
      !drive_out.bus_pullup_connect;
   assign analog_in.vbus_sense_event = sense_evt;
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
`include "osrc_defines.svh"
module tb_top;
   import osrc_pkg::*;
   localparam logic [7:0] ctrl_a = `OSRC_ADDR_SESSION_CTRL;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   osrc_avmm_req_type avmm_req = '0;
   osrc_avmm_rsp_type avmm_rsp;
   osrc_analog_type analog_in;
   osrc_drive_type drive_out;
   logic irq;
   logic sess_on = 1'b0;
   logic lines_busy = 1'b0;
   logic sense_evt = 1'b0;
   logic [31:0] rdata;
   int miscompares = 0;
   int n_checks = 0;
   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;
   osrc_session_request dut_u (.clk_sys(clk_sys), .reset(reset), .avmm_req(avmm_req),
      .avmm_rsp(avmm_rsp), .analog_in(analog_in), .drive_out(drive_out), .irq(irq));
   osrc_host_model host_u (.drive_out(drive_out), .sess_on(sess_on), .lines_busy(lines_busy),
      .sense_evt(sense_evt), .analog_in(analog_in));
   ////////////////////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; bounded wait
   task bus(input logic [7:0] a, input logic rd, input logic [31:0] d);
      int i;
      avmm_req <= '{a, rd, !rd, d};
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (avmm_rsp.waitrequest !== 1'b0 && i < 50);
      if (avmm_rsp.waitrequest !== 1'b0) begin
         miscompares++;
         results();
      end
      rdata = avmm_rsp.readdata;
      avmm_req <= '0;
      @(posedge clk_sys);
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b1, 32'h0);
      chk(rdata, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk({27'h0, drive_out}, 32'h1);
      rdchk(ctrl_a, 32'h0);
      // Unmapped place ignores writes and reads zero
      bus(8'h5C, 1'b0, 32'hFF);
      rdchk(8'h5C, 32'h0);
   endtask
   task t_irq;
      sense_evt <= 1'b1;
      @(posedge clk_sys);
      sense_evt <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      bus(`OSRC_ADDR_IRQ_MASK, 1'b0, 32'h7);
      chk({31'h0, irq}, 32'h1);
      rdchk(`OSRC_ADDR_IRQ_STATUS, 32'h4);
      chk({31'h0, irq}, 32'h0);
      bus(`OSRC_ADDR_IRQ_MASK, 1'b0, 32'h0);
   endtask
   task t_ctrl;
      bus(ctrl_a, 1'b0, 32'hE7);
      chk({27'h0, drive_out}, 32'h1C);
      repeat (2) @(posedge clk_sys);
      rdchk(ctrl_a, 32'h2F);
      bus(ctrl_a, 1'b0, 32'h0);
      chk({27'h0, drive_out}, 32'h1);
      bus(ctrl_a, 1'b0, 32'h26);
      chk({27'h0, drive_out}, 32'h1);
      rdchk(ctrl_a, 32'h26);
      bus(ctrl_a, 1'b0, 32'h0);
   endtask
   task t_init;
      lines_busy <= 1'b1;
      bus(ctrl_a, 1'b0, 32'h1);
      repeat (2) @(posedge clk_sys);
      rdchk(ctrl_a, 32'h9);
      bus(ctrl_a, 1'b0, 32'h9);
      rdchk(ctrl_a, 32'h9);
      lines_busy <= 1'b0;
      bus(ctrl_a, 1'b0, 32'h9);
      repeat (2) @(posedge clk_sys);
      rdchk(ctrl_a, 32'h1);
   endtask
   task t_sess;
      sess_on <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rdchk(ctrl_a, 32'h19);
      sess_on <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rdchk(ctrl_a, 32'h19);
      bus(ctrl_a, 1'b0, 32'h19);
      rdchk(ctrl_a, 32'h1);
      sess_on <= 1'b1;
      bus(ctrl_a, 1'b0, 32'h11);
      rdchk(ctrl_a, 32'h19);
      sess_on <= 1'b0;
      bus(ctrl_a, 1'b0, 32'h0);
      bus(`OSRC_ADDR_MODE, 1'b0, 32'h1);
      chk({27'h0, drive_out}, 32'h3);
      rdchk(`OSRC_ADDR_MODE, 32'h1);
   endtask
   // Full request walk; pulse lengths shortened to fit the run budget
   task t_srp;
      bus(`OSRC_ADDR_MODE, 1'b0, 32'h0);
      bus(ctrl_a, 1'b0, 32'h19);
      repeat (2) @(posedge clk_sys);
      rdchk(ctrl_a, 32'h1);
      bus(ctrl_a, 1'b0, 32'h21);
      chk({27'h0, drive_out}, 32'h10);
      bus(ctrl_a, 1'b0, 32'h1);
      bus(ctrl_a, 1'b0, 32'h3);
      chk({27'h0, drive_out}, 32'h8);
      bus(ctrl_a, 1'b0, 32'h1);
      // Both phases over before the session flag is judged
      rdchk(ctrl_a, 32'h9);
      bus(ctrl_a, 1'b0, 32'h5);
      chk({27'h0, drive_out}, 32'h4);
      bus(ctrl_a, 1'b0, 32'h1);
      sess_on <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rdchk(ctrl_a, 32'h19);
      bus(ctrl_a, 1'b0, 32'h0);
      bus(`OSRC_ADDR_MODE, 1'b0, 32'h1);
      chk({27'h0, drive_out}, 32'h3);
      sess_on <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Reset for six cycles, then the scenarios in turn
   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_irq();
      t_ctrl();
      t_init();
      t_sess();
      t_srp();
      results();
   end
endmodule
bind osrc_session_request osrc_sr_assertions chk_u (.clk_sys(clk_sys), .reset(reset),
   .avmm_req(avmm_req), .avmm_rsp(avmm_rsp), .analog_in(analog_in), .drive_out(drive_out),
   .irq(irq));
